// ---- logic/csr_pkg.sv ----
package csr_pkg;
   localparam int          ADDR_W          = 10;
   localparam int          DATA_W          = 32;
   localparam int          NUM_CH          = 16;
   // Register byte offsets
   localparam logic [9:0]  OFF_MODE        = 10'h064;
   localparam logic [9:0]  OFF_CTRL        = 10'h060;
   localparam logic [9:0]  OFF_EVT_CLR     = 10'h06c;
   localparam logic [9:0]  OFF_STATUS      = 10'h070;
   localparam logic [9:0]  OFF_IRQ_EN      = 10'h074;
   localparam logic [9:0]  OFF_IRQ_DIS     = 10'h078;
   localparam logic [9:0]  OFF_IRQ_MASK    = 10'h07c;
   localparam logic [9:0]  OFF_CH_CLR      = 10'h080;
   localparam logic [9:0]  OFF_CH_STAT     = 10'h084;
   localparam logic [9:0]  OFF_CH_EN       = 10'h088;
   localparam logic [9:0]  OFF_CH_DIS      = 10'h08c;
   localparam logic [9:0]  OFF_CH_MASK     = 10'h090;
   localparam logic [9:0]  OFF_PAYLOAD     = 10'h100;
   localparam logic [9:0]  CH_STRIDE       = 10'h040;
   localparam logic [9:0]  OFF_WORD_B      = 10'h004;
   // Status bit positions
   localparam int          B_ENABLED       = 0;
   localparam int          B_INIT          = 1;
   localparam int          B_INIT_DONE     = 2;
   localparam int          B_ERR_PASSIVE   = 3;
   localparam int          B_BUS_OFF       = 4;
   localparam int          B_ABORT         = 5;
   localparam int          B_SUMMARY       = 7;
   localparam int          REC_LSB         = 16;
   localparam int          TEC_LSB         = 24;
   // Control bits
   localparam int          B_ABORT_SET     = 3;
   localparam int          B_ABORT_CLR     = 4;
   // Mode fields
   localparam int          DIV_LSB         = 0;
   localparam int          DIV_W           = 6;
   localparam int          PS2_LSB         = 20;
   localparam int          PS2_W           = 3;
   localparam logic [2:0]  PS2_RESET       = 3'h1;
   localparam logic [5:0]  DIV_RESET       = 6'h01;
   localparam logic [2:0]  EVT_MASK_LSB    = 3'h2;
   typedef enum logic [2:0] {
      CSR_IDLE = 3'b001,
      CSR_ACK  = 3'b010,
      CSR_WAIT = 3'b100
   } csr_bus_st_t;
endpackage : csr_pkg

// ---- logic/csr_payload_mem.sv ----
`timescale 1ns/1ps
module csr_payload_mem #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [3:0]    be,
   input  wire logic [AW-1:0] addr,
   input  wire logic [31:0]   wdata,
   output logic      [31:0]   rdata
);
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         // One array per lane, so every lane has a single writer
         logic [7:0] lane_mem [DEPTH];
         always_ff @(posedge clk)
         begin
            if (we && be[g])
               lane_mem[addr] <= wdata[g*8 +: 8];
            rdata[g*8 +: 8] <= lane_mem[addr];
         end
      end
   endgenerate
endmodule : csr_payload_mem

// ---- logic/csr_quantum.sv ----
`timescale 1ns/1ps
module csr_quantum (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [5:0] divider,
   input  wire logic [2:0] ps2_field,
   output logic            tq_tick,
   output logic [3:0]      ps2_quanta
);
   logic [5:0] cnt_q;
   // Quantum is divider plus one cycles
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cnt_q   <= 6'h00;
         tq_tick <= 1'b0;
      end
      else if (cnt_q >= divider)
      begin
         cnt_q   <= 6'h00;
         tq_tick <= 1'b1;
      end
      else
      begin
         cnt_q   <= cnt_q + 6'h01;
         tq_tick <= 1'b0;
      end
   end
   // Segment two is field plus one
   always_ff @(posedge clk)
   begin
      if (reset)
         ps2_quanta <= 4'h0;
      else
         ps2_quanta <= {1'b0, ps2_field} + 4'h1;
   end
endmodule : csr_quantum

// ---- logic/csr_status_irq.sv ----
`timescale 1ns/1ps
module csr_status_irq #(
   parameter int NUM_CH = csr_pkg::NUM_CH
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [9:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic              wb_we_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              ctrl_enabled,
   input  wire logic              init_active,
   input  wire logic              err_passive_evt,
   input  wire logic              bus_off_evt,
   input  wire logic [NUM_CH-1:0] chan_irq_evt,
   input  wire logic [NUM_CH-1:0] chan_enabled,
   input  wire logic [7:0]        rx_err_count,
   input  wire logic [7:0]        tx_err_count,
   output logic      [NUM_CH-1:0] chan_disable,
   output logic                   irq,
   output logic                   tq_tick,
   output logic      [3:0]        phase_segment_two,
   output logic      [5:0]        quantum_divider,
   output logic                   abort_active_flag
);
   csr_pkg::csr_bus_st_t st_q;
   logic [31:0] mode_q;
   logic        init_phase_q;
   logic        init_done_flag_q;
   logic        err_passive_flag_q;
   logic        bus_off_flag_q;
   logic [2:0]  evt_mask_q;
   logic [NUM_CH-1:0] chan_pend_q;
   logic [NUM_CH-1:0] chan_mask_q;
   logic        mem_sel_q;
   logic [31:0] rd_q;
   logic [31:0] mem_rdata;
   logic        req;
   logic        wr;
   logic        is_mem;
   logic        mem_we;
   logic [4:0]  mem_addr;
   logic        init_end;
   logic [31:0] status_w;
   logic [31:0] rd_d;
   logic [3:0]  ch_idx;
   logic        tick_w;
   logic [3:0]  ps2_w;

   assign req  = wb_cyc_i && wb_stb_i && (st_q == csr_pkg::CSR_IDLE);
   assign wr   = req && wb_we_i;
   assign is_mem = (wb_adr_i >= csr_pkg::OFF_PAYLOAD) &&
                   (wb_adr_i[5:0] <= csr_pkg::OFF_WORD_B[5:0]) &&
                   (wb_adr_i[1:0] == 2'h0);
   assign ch_idx   = wb_adr_i[9:6] - csr_pkg::OFF_PAYLOAD[9:6];
   assign mem_addr = {ch_idx, wb_adr_i[2]};
   assign mem_we   = wr && is_mem && !init_phase_q;
   // Init end seen as falling phase flag
   assign init_end = init_phase_q && !init_active;

   // Status word assembled from live flags
   always_comb
   begin
      status_w = 32'h0;
      status_w[csr_pkg::B_ENABLED]     = ctrl_enabled;
      status_w[csr_pkg::B_INIT]        = init_phase_q;
      status_w[csr_pkg::B_INIT_DONE]   = init_done_flag_q;
      status_w[csr_pkg::B_ERR_PASSIVE] = err_passive_flag_q;
      status_w[csr_pkg::B_BUS_OFF]     = bus_off_flag_q;
      status_w[csr_pkg::B_ABORT]       = abort_active_flag;
      status_w[csr_pkg::B_SUMMARY]     = |chan_pend_q;
      status_w[csr_pkg::REC_LSB +: 8]  = rx_err_count;
      status_w[csr_pkg::TEC_LSB +: 8]  = tx_err_count;
   end

   always_comb
   begin
      rd_d = 32'h0;
      case (wb_adr_i)
         csr_pkg::OFF_MODE:     rd_d = mode_q;
         csr_pkg::OFF_STATUS:   rd_d = status_w;
         csr_pkg::OFF_IRQ_MASK:
            rd_d[csr_pkg::B_INIT_DONE +: 3] = evt_mask_q;
         csr_pkg::OFF_CH_STAT:  rd_d[NUM_CH-1:0] = chan_pend_q;
         csr_pkg::OFF_CH_MASK:  rd_d[NUM_CH-1:0] = chan_mask_q;
         default:               rd_d = 32'h0;
      endcase
   end

   // Ack two cycles after request, high for one cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_q      <= csr_pkg::CSR_IDLE;
         wb_ack_o  <= 1'b0;
         mem_sel_q <= 1'b0;
         rd_q      <= 32'h0;
      end
      else
      begin
         case (st_q)
            csr_pkg::CSR_IDLE:
            begin
               if (req)
               begin
                  st_q      <= csr_pkg::CSR_ACK;
                  mem_sel_q <= is_mem;
                  rd_q      <= rd_d;
               end
            end
            csr_pkg::CSR_ACK:
            begin
               st_q     <= csr_pkg::CSR_WAIT;
               wb_ack_o <= 1'b1;
            end
            csr_pkg::CSR_WAIT:
            begin
               st_q     <= csr_pkg::CSR_IDLE;
               wb_ack_o <= 1'b0;
            end
            default:
            begin
               st_q     <= csr_pkg::CSR_IDLE;
               wb_ack_o <= 1'b0;
            end
         endcase
      end
   end

   // Data held in a register, memory read lands one cycle later
   always_ff @(posedge clk)
   begin
      if (reset)
         wb_dat_o <= 32'h0;
      else if (st_q == csr_pkg::CSR_ACK)
         wb_dat_o <= mem_sel_q ? mem_rdata : rd_q;
   end

   // Mode register, reset value keeps segment two legal
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode_q <= 32'h0;
         mode_q[csr_pkg::PS2_LSB +: csr_pkg::PS2_W] <= csr_pkg::PS2_RESET;
         mode_q[csr_pkg::DIV_LSB +: csr_pkg::DIV_W] <= csr_pkg::DIV_RESET;
      end
      else if (wr && wb_adr_i == csr_pkg::OFF_MODE)
         mode_q <= wb_dat_i;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         init_phase_q <= 1'b1;
      else
         init_phase_q <= init_active;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         init_done_flag_q <= 1'b0;
      else if (init_end)
         init_done_flag_q <= 1'b1;
      else if (wr && wb_adr_i == csr_pkg::OFF_EVT_CLR &&
               wb_dat_i[csr_pkg::B_INIT_DONE])
         init_done_flag_q <= 1'b0;
   end

   // Sticky transition flags; clear bits chosen locally
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         err_passive_flag_q <= 1'b0;
         bus_off_flag_q     <= 1'b0;
      end
      else
      begin
         if (err_passive_evt)
            err_passive_flag_q <= 1'b1;
         else if (wr && wb_adr_i == csr_pkg::OFF_EVT_CLR &&
                  wb_dat_i[csr_pkg::B_ERR_PASSIVE])
            err_passive_flag_q <= 1'b0;
         if (bus_off_evt)
            bus_off_flag_q <= 1'b1;
         else if (wr && wb_adr_i == csr_pkg::OFF_EVT_CLR &&
                  wb_dat_i[csr_pkg::B_BUS_OFF])
            bus_off_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         evt_mask_q <= 3'h0;
      else if (wr && wb_adr_i == csr_pkg::OFF_IRQ_DIS)
         evt_mask_q <= evt_mask_q & ~wb_dat_i[csr_pkg::B_INIT_DONE +: 3];
      else if (wr && wb_adr_i == csr_pkg::OFF_IRQ_EN)
         evt_mask_q <= evt_mask_q | wb_dat_i[csr_pkg::B_INIT_DONE +: 3];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         abort_active_flag <= 1'b0;
      else if (wr && wb_adr_i == csr_pkg::OFF_CTRL)
      begin
         if (wb_dat_i[csr_pkg::B_ABORT_CLR])
            abort_active_flag <= 1'b0;
         else if (wb_dat_i[csr_pkg::B_ABORT_SET])
            abort_active_flag <= 1'b1;
      end
   end

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++)
      begin : g_ch
         always_ff @(posedge clk)
         begin
            if (reset)
               chan_pend_q[c] <= 1'b0;
            else if (chan_irq_evt[c])
               chan_pend_q[c] <= 1'b1;
            else if (wr && wb_adr_i == csr_pkg::OFF_CH_CLR && wb_dat_i[c])
               chan_pend_q[c] <= 1'b0;
         end
         always_ff @(posedge clk)
         begin
            if (reset)
               chan_mask_q[c] <= 1'b0;
            else if (wr && wb_adr_i == csr_pkg::OFF_CH_DIS && wb_dat_i[c])
               chan_mask_q[c] <= 1'b0;
            else if (wr && wb_adr_i == csr_pkg::OFF_CH_EN && wb_dat_i[c])
               chan_mask_q[c] <= 1'b1;
         end
         // Abort drops enabled channels, owner finishes frame
         always_ff @(posedge clk)
         begin
            if (reset)
               chan_disable[c] <= 1'b0;
            else
               chan_disable[c] <= abort_active_flag && chan_enabled[c];
         end
      end
   endgenerate

   // Combined interrupt, no abort or enable source
   always_ff @(posedge clk)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |({init_done_flag_q, err_passive_flag_q, bus_off_flag_q}
                  & {evt_mask_q[0], evt_mask_q[1], evt_mask_q[2]})
                | |(chan_pend_q & chan_mask_q);
   end

   // Payload words, byte lanes by select
   csr_payload_mem #(
      .DEPTH (2 * NUM_CH),
      .AW    (5)
   ) u_payload (
      .clk   (clk),
      .we    (mem_we),
      .be    (wb_sel_i),
      .addr  (mem_addr),
      .wdata (wb_dat_i),
      .rdata (mem_rdata)
   );

   csr_quantum u_quantum (
      .clk        (clk),
      .reset      (reset),
      .divider    (mode_q[csr_pkg::DIV_LSB +: csr_pkg::DIV_W]),
      .ps2_field  (mode_q[csr_pkg::PS2_LSB +: csr_pkg::PS2_W]),
      .tq_tick    (tick_w),
      .ps2_quanta (ps2_w)
   );

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tq_tick           <= 1'b0;
         phase_segment_two <= 4'h0;
         quantum_divider   <= 6'h0;
      end
      else
      begin
         tq_tick           <= tick_w;
         phase_segment_two <= ps2_w;
         quantum_divider   <= mode_q[csr_pkg::DIV_LSB +: csr_pkg::DIV_W];
      end
   end
endmodule : csr_status_irq

// ---- test/csr_status_irq_chk.sv ----
`timescale 1ns/1ps
module csr_status_irq_chk #(
   parameter int NUM_CH = 16
) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic              wb_ack_o,
   input wire logic [NUM_CH-1:0] chan_enabled,
   input wire logic [NUM_CH-1:0] chan_disable,
   input wire logic              abort_active_flag,
   input wire logic [3:0]        phase_segment_two,
   input wire logic [5:0]        quantum_divider,
   input wire logic              tq_tick,
   input wire logic              irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic [1:0] up_q;
   logic [5:0] gap_q;
   logic [5:0] div_q;
   logic       seen_q;
   // Outputs may still show reset values for a cycle or two
   always_ff @(posedge clk)
   begin
      div_q <= quantum_divider;
      up_q  <= reset ? 2'h0 : (up_q == 2'h3 ? up_q : up_q + 2'h1);
      gap_q <= (reset || tq_tick) ? 6'h00 : gap_q + 6'h01;
      // Divider change leaves the quantum count running, old gap meaningless
      if (reset || div_q != quantum_divider)
         seen_q <= 1'b0;
      else if (tq_tick)
         seen_q <= 1'b1;
   end
   property p_ack_lat; $rose(wb_cyc_i && wb_stb_i) |-> ##2 wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_ack_req;
      wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i, 2);
   endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack without request");
   property p_abort_dis;
      chan_disable == ($past(chan_enabled) & {NUM_CH{$past(abort_active_flag)}});
   endproperty
   a_abort_dis: assert property (p_abort_dis)
      else $error("channel disable wrong");
   property p_abort_wr;
      abort_active_flag != $past(abort_active_flag) |-> $past(wb_cyc_i && wb_we_i);
   endproperty
   a_abort_wr: assert property (p_abort_wr)
      else $error("abort changed without write");
   property p_ps2; up_q == 2'h3 |-> phase_segment_two inside {[4'h2:4'h8]}; endproperty
   a_ps2: assert property (p_ps2) else $error("segment two out of range");
   property p_div; up_q == 2'h3 |-> quantum_divider != 6'h00; endproperty
   a_div: assert property (p_div) else $error("divider zero");
   // A tick launched under the old divider can land after the change
   property p_tq;
      tq_tick && seen_q && div_q == quantum_divider
         |-> gap_q == quantum_divider;
   endproperty
   a_tq: assert property (p_tq) else $error("quantum period wrong");
   c_abort: cover property ($rose(abort_active_flag));
   c_irq: cover property ($rose(irq));
   c_dis: cover property (|chan_disable);
endmodule : csr_status_irq_chk

bind csr_status_irq csr_status_irq_chk #(.NUM_CH(NUM_CH)) u_chk (.clk, .reset,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .chan_enabled, .chan_disable,
   .abort_active_flag, .phase_segment_two, .quantum_divider, .tq_tick, .irq);

// ---- test/csr_far_model.sv ----
`timescale 1ns/1ps
module csr_far_model (
   input  wire logic        clk,
   output logic             ctrl_enabled,
   output logic             init_active,
   output logic             err_passive_evt,
   output logic             bus_off_evt,
   output logic [15:0]      chan_irq_evt,
   output logic [15:0]      chan_enabled,
   output logic [7:0]       rx_err_count,
   output logic [7:0]       tx_err_count
);
   initial
   begin
      {ctrl_enabled, init_active, err_passive_evt, bus_off_evt} = 4'h4;
      {chan_irq_evt, chan_enabled} = 32'h0;
      {rx_err_count, tx_err_count} = 16'h0;
   end
   // Events last exactly one clock, as the error logic beats them
   task automatic beat(input logic ep, input logic bo, input logic [15:0] ev);
      err_passive_evt <= ep;
      bus_off_evt     <= bo;
      chan_irq_evt    <= ev;
      @(posedge clk);
      {err_passive_evt, bus_off_evt} <= 2'h0;
      chan_irq_evt    <= 16'h0000;
   endtask : beat
   task automatic lvl(input logic en, input logic ini, input logic [15:0] chen,
                      input logic [7:0] rx, input logic [7:0] tx);
      ctrl_enabled <= en;
      init_active  <= ini;
      chan_enabled <= chen;
      rx_err_count <= rx;
      tx_err_count <= tx;
   endtask : lvl
endmodule : csr_far_model

// ---- test/test_can_status_interrupt_regs.sv ----
`timescale 1ns/1ps
module test_can_status_interrupt_regs;
   logic        clk, reset, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
   logic        ctrl_enabled, init_active, err_passive_evt, bus_off_evt;
   logic        tq_tick, abort_active_flag;
   logic [9:0]  wb_adr_i, a;
   logic [31:0] wb_dat_i, wb_dat_o, v, w;
   logic [3:0]  wb_sel_i, phase_segment_two, ch;
   logic [15:0] chan_irq_evt, chan_enabled, chan_disable, e, m;
   logic [7:0]  rx_err_count, tx_err_count;
   logic [5:0]  quantum_divider, dv;
   logic [31:0] exp_q[$];
   int          mismatches, cmp_count;

   csr_status_irq DUT (.clk, .reset, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .ctrl_enabled,
      .init_active, .err_passive_evt, .bus_off_evt, .chan_irq_evt,
      .chan_enabled, .rx_err_count, .tx_err_count, .chan_disable, .irq,
      .tq_tick, .phase_segment_two, .quantum_divider, .abort_active_flag);
   csr_far_model far (.clk, .ctrl_enabled, .init_active, .err_passive_evt,
      .bus_off_evt, .chan_irq_evt, .chan_enabled, .rx_err_count,
      .tx_err_count);

   always #5 clk = ~clk;

   task automatic give_verdict();
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic xfer(input logic [9:0] ad, input logic wr,
                       input logic [31:0] d, input logic [3:0] s);
      wb_adr_i <= ad;
      wb_we_i  <= wr;
      wb_dat_i <= d;
      wb_sel_i <= s;
      {wb_cyc_i, wb_stb_i} <= 2'h3;
      do
         @(posedge clk);
      while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clk);
   endtask : xfer
   task automatic wr(input logic [9:0] ad, input logic [31:0] d);
      xfer(ad, 1'b1, d, 4'hf);
   endtask : wr
   task automatic rd(input logic [9:0] ad, input logic [31:0] x);
      exp_q.push_back(x);
      xfer(ad, 1'b0, 32'h0, 4'hf);
   endtask : rd
   function automatic logic [31:0] st(input logic [7:0] b);
      return {tx_err_count, rx_err_count, 8'h00, b};
   endfunction : st
   task automatic rst();
      reset <= 1'b1;
      tick(12);
      reset <= 1'b0;
   endtask : rst

   // Read data is compared when the slave answers
   always @(posedge clk)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         cmp(wb_dat_o, exp_q.pop_front());
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
      wb_adr_i = 10'h000;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      mismatches = 0;
      cmp_count = 0;
      void'($urandom(32'h5180));
      far.lvl(1'b0, 1'b1, 16'h0000, 8'($urandom), 8'($urandom));
      rst();
      rd(10'h070, st(8'h02));
      rd(10'h07c, 32'h0);
      rd(10'h084, 32'h0);
      rd(10'h090, 32'h0);
      rd(10'h094, 32'h0);
      far.lvl(1'b0, 1'b0, 16'h0000, rx_err_count, tx_err_count);
      tick(2);
      rd(10'h070, st(8'h04));
      v = $urandom;
      w = $urandom;
      wr(10'h240, v);
      far.lvl(1'b0, 1'b1, 16'h0000, rx_err_count, tx_err_count);
      rst();
      wr(10'h240, w);
      far.lvl(1'b0, 1'b0, 16'h0000, rx_err_count, tx_err_count);
      tick(2);
      rd(10'h240, v);
      wr(10'h074, 32'h4);
      rd(10'h07c, 32'h4);
      cmp(32'(irq), 32'h1);
      wr(10'h06c, 32'h0);
      rd(10'h070, st(8'h04));
      wr(10'h06c, 32'h4);
      rd(10'h070, st(8'h00));
      cmp(32'(irq), 32'h0);
      wr(10'h074, 32'h18);
      far.beat(1'b1, 1'b0, 16'h0000);
      tick(3);
      rd(10'h070, st(8'h08));
      cmp(32'(irq), 32'h1);
      wr(10'h078, 32'h08);
      rd(10'h07c, 32'h14);
      cmp(32'(irq), 32'h0);
      far.beat(1'b0, 1'b1, 16'h0000);
      tick(3);
      rd(10'h070, st(8'h18));
      cmp(32'(irq), 32'h1);
      wr(10'h06c, 32'h18);
      far.lvl(1'b1, 1'b0, 16'h0000, rx_err_count, tx_err_count);
      tick(3);
      rd(10'h070, st(8'h01));
      cmp(32'(irq), 32'h0);
      e = 16'($urandom) | 16'h0101;
      m = 16'($urandom);
      far.beat(1'b0, 1'b0, e);
      tick(3);
      rd(10'h084, {16'h0, e});
      rd(10'h070, st(8'h81));
      wr(10'h088, {16'h0, m});
      rd(10'h090, {16'h0, m});
      cmp(32'(irq), 32'(|(e & m)));
      wr(10'h08c, 32'hffff);
      rd(10'h090, 32'h0);
      cmp(32'(irq), 32'h0);
      wr(10'h080, 32'h00ff);
      rd(10'h084, {16'h0, e & 16'hff00});
      wr(10'h080, 32'hffff);
      rd(10'h070, st(8'h01));
      far.lvl(1'b1, 1'b0, 16'($urandom), rx_err_count, tx_err_count);
      wr(10'h060, 32'h08);
      rd(10'h070, st(8'h21));
      cmp(32'(chan_disable), 32'(chan_enabled));
      cmp(32'(irq), 32'h0);
      wr(10'h060, 32'h18);
      rd(10'h070, st(8'h01));
      cmp(32'(chan_disable), 32'h0);
      for (int f = 1; f < 8; f++)
      begin
         dv = 6'(1 + $urandom_range(5));
         // Field never zero, jump width two quanta for long segments
         wr(10'h064, {9'h0, 3'(f), 7'h0, 1'b1, 6'h0, dv});
         tick(20);
         cmp(32'(phase_segment_two), 32'(f + 1));
         cmp(32'(quantum_divider), 32'(dv));
      end
      // Channels past eleven fall outside the ten-bit address space
      for (int c = 0; c < 12; c++)
      begin
         ch = 4'(c);
         a = {ch, 6'h00} + 10'h100;
         v = $urandom;
         w = $urandom;
         wr(a, v);
         wr(a + 10'h004, w);
         rd(a, v);
         rd(a + 10'h004, w);
      end
      w = $urandom;
      xfer(a, 1'b1, w, 4'h2);
      rd(a, (v & 32'hffff00ff) | (w & 32'h0000ff00));
      give_verdict();
   end
endmodule : test_can_status_interrupt_regs
